// ===== design/spf_ctrl.sv
// self program flash control: command register, arming windows, sequencing
//
// Contract
// - register answers at memory and I/O address
// - ready interrupt requested while store enable clear
// - no ready interrupt during eeprom write or store
// - section busy bit reads zero always
// - signature command: load returns signature, store ignored
// - section read enable during fill clears buffer
// - lock command: load returns lock or fuse byte
// - page write command programs buffer into page
// - page write bit clears on completion or timeout
// - page erase command erases addressed page
// - page erase bit clears on completion or timeout
// - core stalled during erase and write
// - store enable permits store for four cycles
// - plain store puts word into page buffer
// - store enable clears on completion or timeout
// - illegal low five bit combinations ignored
// - boot code may program any page
// - pointer low bits select lock or fuse byte
// - programmed bits read as zero
// - erase and write last 3.2 to 3.4 ms
// - store from application starts nothing
`timescale 1ns/100ps
module spf_ctrl
    import spf_pkg::*;
#(
    parameter int PAGE_WORD_BITS = 6,
    parameter int PROG_CYCLES = spf_pkg::PROG_CYCLES_DEF
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] BUS_ADDR,
    input wire logic BUS_IO,
    input wire logic BUS_WE,
    input wire logic BUS_RE,
    input wire logic [7:0] BUS_WDATA,
    output logic [7:0] BUS_RDATA,
    input wire logic SPM_EXEC,
    input wire logic LPM_EXEC,
    input wire logic [15:0] Z_PTR,
    input wire logic [15:0] DATA_WORD,
    input wire logic FROM_BOOT,
    input wire logic GLOBAL_IE,
    input wire logic EE_WRITE_BUSY,
    input wire logic [7:0] LOCK_BITS,
    input wire logic [7:0] FUSE_LOW,
    input wire logic [7:0] FUSE_HIGH,
    input wire logic [7:0] FUSE_EXT,
    input wire logic [7:0] SIG_BYTE,
    output logic LPM_VALID,
    output logic [7:0] LPM_DATA,
    output logic BUF_WE,
    output logic [PAGE_WORD_BITS-1:0] BUF_WADDR,
    output logic [15:0] BUF_WDATA,
    output logic BUF_CLEAR,
    output logic FLASH_ERASE,
    output logic FLASH_WRITE,
    output logic [14-PAGE_WORD_BITS:0] FLASH_PAGE,
    output logic CPU_HALT,
    output logic READY_IRQ
);
    import spf_pkg::*;

    localparam int PW = 15 - PAGE_WORD_BITS;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    spf_state_t state, next_state;
    logic irq_en, next_irq_en;
    logic [5:0] cmd, next_cmd;
    logic [2:0] win, next_win;
    logic filling, next_filling;
    logic timer_start, timer_done;
    logic next_lpm_valid, next_buf_we, next_buf_clear, next_halt, next_irq;
    logic [7:0] next_lpm_data, next_rdata, reg_value, lock_pick;
    logic [PAGE_WORD_BITS-1:0] next_buf_waddr;
    logic [15:0] next_buf_wdata;
    logic [PW-1:0] next_page;
    logic hit, wr, legal, sig_wr;
    logic [4:0] low5;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    assign hit = BUS_IO ? (BUS_ADDR == REG_IO_ADDR) : (BUS_ADDR == REG_MEM_ADDR);
    assign wr = BUS_WE && hit;
    assign low5 = BUS_WDATA[4:0];
    assign legal = (low5 == CMD_FILL) || (low5 == CMD_ERASE) || (low5 == CMD_WRITE)
                   || (low5 == CMD_LOCK) || (low5 == CMD_SECT);
    // signature read only rides with a plain store enable
    assign sig_wr = BUS_WDATA[BIT_SIG_READ] && (low5 == CMD_FILL);
    assign reg_value = {irq_en, 1'b0, cmd};

    // lock and fuse cells are passed raw: a programmed cell already reads zero
    always_comb begin
        lock_pick = FUSE_LOW;
        unique case (Z_PTR[1:0])
            SEL_LOCK: lock_pick = LOCK_BITS;
            SEL_FUSE_EXT: lock_pick = FUSE_EXT;
            SEL_FUSE_HIGH: lock_pick = FUSE_HIGH;
            SEL_FUSE_LOW: lock_pick = FUSE_LOW;
        endcase
    end

    // ------------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------------
    // command bits are taken only while idle; a second write during the
    // window or an operation cannot retarget a store already armed
    always_comb begin
        next_state = state;
        next_irq_en = irq_en;
        next_cmd = cmd;
        next_win = win;
        next_filling = filling;
        next_lpm_valid = 1'b0;
        next_lpm_data = LPM_DATA;
        next_buf_we = 1'b0;
        next_buf_waddr = BUF_WADDR;
        next_buf_wdata = BUF_WDATA;
        next_buf_clear = 1'b0;
        next_page = FLASH_PAGE;
        timer_start = 1'b0;
        if (wr) begin
            next_irq_en = BUS_WDATA[BIT_IRQ_EN];
        end
        unique case (state)
            ST_IDLE: begin
                if (wr && legal) begin
                    next_cmd = {sig_wr, low5};
                    next_state = ST_ARMED;
                    next_win = 3'h0;
                    if (low5 == CMD_SECT && filling) begin
                        next_buf_clear = 1'b1;
                        next_filling = 1'b0;
                    end
                end
            end
            ST_ARMED: begin
                next_win = win + 3'h1;
                if (SPM_EXEC) begin
                    next_cmd = 6'h00;
                    next_state = ST_IDLE;
                    if (!FROM_BOOT) begin
                        next_cmd = 6'h00;
                    end else if (cmd[4:0] == CMD_ERASE || cmd[4:0] == CMD_WRITE) begin
                        // whole flash reachable from boot code, no section limit
                        next_cmd = cmd;
                        next_state = ST_BUSY;
                        timer_start = 1'b1;
                        next_page = Z_PTR[15:PAGE_WORD_BITS+1];
                    end else if (cmd == {1'b0, CMD_FILL}) begin
                        next_buf_we = 1'b1;
                        next_buf_waddr = Z_PTR[PAGE_WORD_BITS:1];
                        next_buf_wdata = DATA_WORD;
                        next_filling = 1'b1;
                    end
                    // signature and lock modes: store has no effect
                end else if (LPM_EXEC && win < LOAD_WIN && (cmd[BIT_LOCK_FUSE] || cmd[BIT_SIG_READ])) begin
                    next_lpm_valid = 1'b1;
                    next_lpm_data = cmd[BIT_SIG_READ] ? SIG_BYTE : lock_pick;
                    next_cmd = 6'h00;
                    next_state = ST_IDLE;
                end else if (win == STORE_WIN - 3'h1) begin
                    next_cmd = 6'h00;
                    next_state = ST_IDLE;
                end
            end
            ST_BUSY: begin
                if (timer_done) begin
                    if (cmd[BIT_PAGE_WRITE]) begin
                        next_filling = 1'b0;
                    end
                    next_cmd = 6'h00;
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // outputs are computed from next values so they line up with the state
    always_comb begin
        next_halt = (next_state == ST_BUSY);
        next_irq = next_irq_en && GLOBAL_IE && !next_cmd[BIT_STORE_EN]
                   && !EE_WRITE_BUSY && (next_state != ST_BUSY);
        next_rdata = (BUS_RE && hit) ? reg_value : 8'h00;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            irq_en <= REG_RESET[BIT_IRQ_EN];
            cmd <= REG_RESET[5:0];
            win <= 3'h0;
            filling <= 1'b0;
            BUS_RDATA <= 8'h00;
            LPM_VALID <= 1'b0;
            LPM_DATA <= 8'h00;
            BUF_WE <= 1'b0;
            BUF_WADDR <= '0;
            BUF_WDATA <= 16'h0000;
            BUF_CLEAR <= 1'b0;
            FLASH_ERASE <= 1'b0;
            FLASH_WRITE <= 1'b0;
            FLASH_PAGE <= '0;
            CPU_HALT <= 1'b0;
            READY_IRQ <= 1'b0;
        end else begin
            state <= next_state;
            irq_en <= next_irq_en;
            cmd <= next_cmd;
            win <= next_win;
            filling <= next_filling;
            BUS_RDATA <= next_rdata;
            LPM_VALID <= next_lpm_valid;
            LPM_DATA <= next_lpm_data;
            BUF_WE <= next_buf_we;
            BUF_WADDR <= next_buf_waddr;
            BUF_WDATA <= next_buf_wdata;
            BUF_CLEAR <= next_buf_clear;
            FLASH_ERASE <= next_halt && next_cmd[BIT_PAGE_ERASE];
            FLASH_WRITE <= next_halt && next_cmd[BIT_PAGE_WRITE];
            FLASH_PAGE <= next_page;
            CPU_HALT <= next_halt;
            READY_IRQ <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // programming timer
    // ------------------------------------------------------------------
    // microsecond resolution keeps the counter small; the 1 us granularity
    // is well inside the allowed spread of the programming time
    spf_prog_timer #(
        .DIV(TICK_CYCLES),
        .TICKS(PROG_CYCLES / TICK_CYCLES)
    ) u_timer (
        .clk(CLOCK),
        .rst(RST),
        .start(timer_start),
        .done(timer_done)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_io_alias;
        @(posedge CLOCK) disable iff (RST)
        (BUS_RE && BUS_IO && BUS_ADDR == REG_IO_ADDR) |=> BUS_RDATA == $past(reg_value);
    endproperty
    a_io_alias: assert property (p_io_alias) else $error("io alias read wrong");

    property p_irq_idle;
        @(posedge CLOCK) disable iff (RST)
        (irq_en && GLOBAL_IE && !EE_WRITE_BUSY && state == ST_IDLE && !wr) |=> READY_IRQ;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("ready irq missing");

    property p_irq_quiet;
        @(posedge CLOCK) disable iff (RST)
        (CPU_HALT || $past(EE_WRITE_BUSY)) |-> !READY_IRQ;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("ready irq while busy");

    property p_busy_bit;
        @(posedge CLOCK) disable iff (RST) !BUS_RDATA[BIT_SECT_BUSY];
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit not zero");

    property p_illegal;
        @(posedge CLOCK) disable iff (RST)
        (wr && !legal && state == ST_IDLE) |=> (state == ST_IDLE && cmd == 6'h00);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal command taken");

    property p_window;
        @(posedge CLOCK) disable iff (RST)
        (state == ST_IDLE ##1 state == ST_ARMED) |-> ##[1:4] state != ST_ARMED;
    endproperty
    a_window: assert property (p_window) else $error("arming window too long");

    property p_erase_halt;
        @(posedge CLOCK) disable iff (RST)
        (state == ST_ARMED && SPM_EXEC && FROM_BOOT && cmd[4:0] == CMD_ERASE)
        |=> (CPU_HALT && FLASH_ERASE && cmd[BIT_STORE_EN]) [*3];
    endproperty
    a_erase_halt: assert property (p_erase_halt) else $error("erase not stalling core");

    property p_app_store;
        @(posedge CLOCK) disable iff (RST)
        (state == ST_ARMED && SPM_EXEC && !FROM_BOOT) |=> (!CPU_HALT && !BUF_WE);
    endproperty
    a_app_store: assert property (p_app_store) else $error("application store acted");

    property p_fill;
        @(posedge CLOCK) disable iff (RST)
        (state == ST_ARMED && SPM_EXEC && FROM_BOOT && cmd == {1'b0, CMD_FILL})
        |=> (BUF_WE && BUF_WDATA == $past(DATA_WORD) && cmd == 6'h00);
    endproperty
    a_fill: assert property (p_fill) else $error("buffer fill wrong");

    property p_lock_read;
        @(posedge CLOCK) disable iff (RST)
        (state == ST_ARMED && !SPM_EXEC && LPM_EXEC && win < LOAD_WIN && cmd[4:0] == CMD_LOCK)
        |=> (LPM_VALID && LPM_DATA == $past(lock_pick));
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

    property p_sect_clear;
        @(posedge CLOCK) disable iff (RST)
        (wr && state == ST_IDLE && low5 == CMD_SECT && filling) |=> BUF_CLEAR;
    endproperty
    a_sect_clear: assert property (p_sect_clear) else $error("buffer not cleared");
endmodule

// ===== design/spf_pkg.sv
// shared constants and types for the self program flash control block
package spf_pkg;

    // ------------------------------------------------------------------
    // register placement
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_MEM_ADDR = 8'h57;
    localparam logic [7:0] REG_IO_SHIFT = 8'h20;
    localparam logic [7:0] REG_IO_ADDR = REG_MEM_ADDR - REG_IO_SHIFT;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------------
    // field positions of program_memory_store_control
    // ------------------------------------------------------------------
    localparam int BIT_STORE_EN = 0;
    localparam int BIT_PAGE_ERASE = 1;
    localparam int BIT_PAGE_WRITE = 2;
    localparam int BIT_LOCK_FUSE = 3;
    localparam int BIT_SECT_READ = 4;
    localparam int BIT_SIG_READ = 5;
    localparam int BIT_SECT_BUSY = 6;
    localparam int BIT_IRQ_EN = 7;

    // ------------------------------------------------------------------
    // legal values of the low five command bits
    // ------------------------------------------------------------------
    localparam logic [4:0] CMD_FILL = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_SECT = 5'h11;

    // ------------------------------------------------------------------
    // arming windows, in clock cycles after the register write
    // ------------------------------------------------------------------
    localparam logic [2:0] STORE_WIN = 3'h4;
    localparam logic [2:0] LOAD_WIN = 3'h3;

    // ------------------------------------------------------------------
    // pointer codes for the lock and fuse read
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
    localparam logic [1:0] SEL_LOCK = 2'h1;
    localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
    localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;

    // ------------------------------------------------------------------
    // programming time
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int PROG_MIN_US = 3200;
    localparam int PROG_MAX_US = 3400;
    localparam int PROG_MIN_CYCLES = PROG_MIN_US * CLK_MHZ;
    localparam int PROG_MAX_CYCLES = PROG_MAX_US * CLK_MHZ;
    localparam int PROG_CYCLES_DEF = (PROG_MIN_CYCLES + PROG_MAX_CYCLES) / 2;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_BUSY = 3'b100
    } spf_state_t;

endpackage

// ===== design/spf_prog_timer.sv
// programming duration timer: microsecond divider and tick counter
`timescale 1ns/100ps
module spf_prog_timer #(
    parameter int DIV = 40,
    parameter int TICKS = 3300
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic done
);
    localparam int DW = $clog2(DIV + 1);
    localparam int TW = $clog2(TICKS + 1);
    localparam logic [DW-1:0] DIV_LOAD = DW'(DIV - 1);
    localparam logic [TW-1:0] TICK_LOAD = TW'(TICKS);
    localparam logic [TW-1:0] TICK_LAST = TW'(1);

    logic [DW-1:0] pre, next_pre;
    logic [TW-1:0] cnt, next_cnt;
    logic run, next_run, next_done;

    // divider gives a one-cycle tick, the counter ends the operation
    always_comb begin
        next_pre = pre;
        next_cnt = cnt;
        next_run = run;
        next_done = 1'b0;
        if (start) begin
            next_run = 1'b1;
            next_pre = DIV_LOAD;
            next_cnt = TICK_LOAD;
        end else if (run) begin
            if (pre == '0) begin
                next_pre = DIV_LOAD;
                if (cnt == TICK_LAST) begin
                    next_run = 1'b0;
                    next_done = 1'b1;
                end
                next_cnt = cnt - TICK_LAST;
            end else begin
                next_pre = pre - DW'(1);
            end
        end
    end

    // state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre <= '0;
            cnt <= '0;
            run <= 1'b0;
            done <= 1'b0;
        end else begin
            pre <= next_pre;
            cnt <= next_cnt;
            run <= next_run;
            done <= next_done;
        end
    end

    property p_done_after_run;
        @(posedge clk) disable iff (rst) done |-> $past(run);
    endproperty
    a_done_after_run: assert property (p_done_after_run) else $error("done without run");
endmodule

// ===== sim/spf_core_model.sv
// core side model: fuse and lock cells, signature row, temporary page buffer
`timescale 1ns/100ps
module spf_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] z,
    input wire logic buf_we,
    input wire logic [5:0] buf_waddr,
    input wire logic [15:0] buf_wdata,
    input wire logic buf_clear,
    output logic [7:0] lock_bits,
    output logic [7:0] fuse_low,
    output logic [7:0] fuse_high,
    output logic [7:0] fuse_ext,
    output logic [7:0] sig_byte,
    output logic [7:0] fill_cnt,
    output logic [5:0] last_addr,
    output logic [15:0] last_word
);
    // ------------------------------------------------------------------
    // cell contents
    // ------------------------------------------------------------------
    // raw cells, a zero bit is a programmed cell; values differ so a wrong pick shows
    assign lock_bits = 8'hFC;
    assign fuse_low = 8'h62;
    assign fuse_high = 8'hDF;
    assign fuse_ext = 8'hF9;
    // follows the pointer so a stale byte is caught; reserved read, used by one test only
    assign sig_byte = {4'h5, z[3:0]};

    // ------------------------------------------------------------------
    // page buffer
    // ------------------------------------------------------------------
    // counts words held since the last clear and keeps the last word written
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fill_cnt <= 8'h00;
            last_addr <= 6'h00;
            last_word <= 16'h0000;
        end else if (buf_clear) begin
            fill_cnt <= 8'h00;
        end else if (buf_we) begin
            fill_cnt <= fill_cnt + 8'h01;
            last_addr <= buf_waddr;
            last_word <= buf_wdata;
        end
    end
endmodule

// ===== sim/spf_ctrl_bench.sv
// self-checking bench for the self program flash control block
`timescale 1ns/100ps
module spf_ctrl_bench;
    import spf_pkg::*;
    localparam int PC = 400;
`define CHECK_EQ(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rd, lpm_byte;
    logic io = 0, we = 0, re = 0, spm = 0, lpm = 0, boot = 1, gie = 0, ee = 0;
    logic [15:0] z = 16'h0000, dword = 16'h0000;
    wire logic [7:0] rdata, lpm_data, lock_bits, fuse_low, fuse_high, fuse_ext, sig_byte;
    wire logic [7:0] fill_cnt;
    wire logic lpm_valid, buf_we, buf_clear, f_erase, f_write, halt, irq;
    wire logic [5:0] buf_waddr, last_addr;
    wire logic [15:0] buf_wdata, last_word;
    wire logic [8:0] page;
    int error_cnt = 0, cmp_count = 0, lpm_seen = 0, halt_cyc = 0, op_cyc = 0, clr = 0;
    int wr_cyc = 0;
    int n, h, k, w;
    logic [7:0] fuse_exp [4];

    spf_ctrl #(.PAGE_WORD_BITS(6), .PROG_CYCLES(PC)) i_spf_ctrl (.CLOCK(clock), .RST(rst),
        .BUS_ADDR(addr), .BUS_IO(io), .BUS_WE(we), .BUS_RE(re), .BUS_WDATA(wdata),
        .BUS_RDATA(rdata), .SPM_EXEC(spm), .LPM_EXEC(lpm), .Z_PTR(z), .DATA_WORD(dword),
        .FROM_BOOT(boot), .GLOBAL_IE(gie), .EE_WRITE_BUSY(ee), .LOCK_BITS(lock_bits),
        .FUSE_LOW(fuse_low), .FUSE_HIGH(fuse_high), .FUSE_EXT(fuse_ext), .SIG_BYTE(sig_byte),
        .LPM_VALID(lpm_valid), .LPM_DATA(lpm_data), .BUF_WE(buf_we), .BUF_WADDR(buf_waddr),
        .BUF_WDATA(buf_wdata), .BUF_CLEAR(buf_clear), .FLASH_ERASE(f_erase),
        .FLASH_WRITE(f_write), .FLASH_PAGE(page), .CPU_HALT(halt), .READY_IRQ(irq));
    spf_core_model i_spf_core_model (.clk(clock), .rst(rst), .z(z), .buf_we(buf_we),
        .buf_waddr(buf_waddr), .buf_wdata(buf_wdata), .buf_clear(buf_clear),
        .lock_bits(lock_bits), .fuse_low(fuse_low), .fuse_high(fuse_high),
        .fuse_ext(fuse_ext), .sig_byte(sig_byte), .fill_cnt(fill_cnt),
        .last_addr(last_addr), .last_word(last_word));

    // ------------------------------------------------------------------
    // clock, monitors and bus tasks
    // ------------------------------------------------------------------
    always #12.5 clock = ~clock;
    // pulse and level counters, sampled before the edge's own updates land
    always @(posedge clock) begin
        if (lpm_valid === 1'b1) begin
            lpm_seen++;
            lpm_byte = lpm_data;
        end
        if (halt === 1'b1) halt_cyc++;
        if (f_erase === 1'b1 || f_write === 1'b1) op_cyc++;
        // write cycles alone, so a swapped erase and write strobe shows
        if (f_write === 1'b1) wr_cyc++;
        if (buf_clear === 1'b1) clr++;
    end
    task reg_wr(input logic [7:0] a, input logic m, input logic [7:0] d);
        @(negedge clock);
        addr = a;
        io = m;
        wdata = d;
        we = 1'b1;
        @(negedge clock);
        we = 1'b0;
    endtask
    task reg_rd(input logic [7:0] a, input logic m);
        @(negedge clock);
        addr = a;
        io = m;
        re = 1'b1;
        @(negedge clock);
        re = 1'b0;
        rd = rdata;
    endtask
    // gap 0 lands on the first edge after the arming write
    task exec(input logic store, input logic [15:0] zz, input int gap);
        z = zz;
        repeat (gap) @(negedge clock);
        spm = store;
        lpm = !store;
        @(negedge clock);
        spm = 1'b0;
        lpm = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task wait_idle;
        for (k = 0; k < 1000 && halt !== 1'b0; k++) @(negedge clock);
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_regs;
        reg_rd(REG_MEM_ADDR, 1'b0);
        `CHECK_EQ(rd, REG_RESET)
        reg_wr(REG_IO_ADDR, 1'b1, 8'hC0);
        reg_rd(REG_MEM_ADDR, 1'b0);
        `CHECK_EQ(rd, 8'h80)
        reg_rd(REG_IO_ADDR, 1'b0);
        `CHECK_EQ(rd, 8'h00)
        // alias read while the register holds a nonzero value, so a dead decode shows
        reg_rd(REG_IO_ADDR, 1'b1);
        `CHECK_EQ(rd, 8'h80)
        reg_wr(REG_MEM_ADDR, 1'b0, 8'h00);
    endtask
    task t_illegal;
        logic [4:0] bad [5];
        bad = '{5'h07, 5'h0B, 5'h02, 5'h10, 5'h1F};
        for (int i = 0; i < 5; i++) begin
            reg_wr(REG_MEM_ADDR, 1'b0, {3'h0, bad[i]});
            reg_rd(REG_MEM_ADDR, 1'b0);
            `CHECK_EQ(rd, 8'h00)
        end
    endtask
    task t_fill;
        dword = 16'hBEEF;
        reg_wr(REG_MEM_ADDR, 1'b0, {3'h0, CMD_FILL});
        exec(1'b1, 16'h0043, 3);
        `CHECK_EQ(fill_cnt, 8'h01)
        `CHECK_EQ({last_addr, last_word}, {6'h21, 16'hBEEF})
        reg_rd(REG_MEM_ADDR, 1'b0);
        `CHECK_EQ(rd, 8'h00)
        reg_wr(REG_MEM_ADDR, 1'b0, {3'h0, CMD_FILL});
        exec(1'b1, 16'h0002, 4);
        `CHECK_EQ(fill_cnt, 8'h01)
        n = lpm_seen;
        reg_wr(REG_MEM_ADDR, 1'b0, {3'h0, CMD_LOCK});
        exec(1'b0, 16'h0001, 3);
        `CHECK_EQ(lpm_seen, n)
        n = clr;
        reg_wr(REG_MEM_ADDR, 1'b0, {3'h0, CMD_SECT});
        exec(1'b1, 16'h0000, 0);
        `CHECK_EQ(clr, n + 1)
        `CHECK_EQ(fill_cnt, 8'h00)
    endtask
    task t_prog;
        for (int op = 0; op < 2; op++) begin
            reg_wr(REG_MEM_ADDR, 1'b0, {3'h0, (op == 0) ? CMD_ERASE : CMD_WRITE});
            h = halt_cyc;
            n = op_cyc;
            w = wr_cyc;
            exec(1'b1, (op == 0) ? 16'hFF80 : 16'h0000, 1);
            `CHECK_EQ(page, (op == 0) ? 9'h1FF : 9'h000)
            reg_rd(REG_MEM_ADDR, 1'b0);
            `CHECK_EQ(rd, {3'h0, (op == 0) ? CMD_ERASE : CMD_WRITE})
            wait_idle();
            `CHECK_EQ(halt_cyc - h >= PC && halt_cyc - h <= PC + 2, 1'b1)
            `CHECK_EQ(op_cyc - n, halt_cyc - h)
            `CHECK_EQ(wr_cyc - w, (op == 0) ? 0 : halt_cyc - h)
            reg_rd(REG_MEM_ADDR, 1'b0);
            `CHECK_EQ(rd, 8'h00)
        end
        boot = 1'b0;
        h = halt_cyc;
        reg_wr(REG_MEM_ADDR, 1'b0, {3'h0, CMD_ERASE});
        exec(1'b1, 16'h0000, 0);
        `CHECK_EQ(halt_cyc, h)
        boot = 1'b1;
    endtask
    task t_read;
        fuse_exp = '{fuse_low, lock_bits, fuse_ext, fuse_high};
        for (int i = 0; i < 4; i++) begin
            n = lpm_seen;
            reg_wr(REG_MEM_ADDR, 1'b0, {3'h0, CMD_LOCK});
            exec(1'b0, 16'(i), 2);
            `CHECK_EQ({lpm_seen == n + 1, lpm_byte}, {1'b1, fuse_exp[i]})
        end
        n = lpm_seen;
        reg_wr(REG_MEM_ADDR, 1'b0, 8'h21);
        exec(1'b0, 16'h0007, 0);
        `CHECK_EQ({lpm_seen == n + 1, lpm_byte}, {1'b1, 8'h57})
        reg_wr(REG_MEM_ADDR, 1'b0, 8'h21);
        exec(1'b1, 16'h0000, 1);
        `CHECK_EQ({fill_cnt, halt_cyc == h}, {8'h00, 1'b1})
    endtask
    task t_irq;
        reg_wr(REG_MEM_ADDR, 1'b0, 8'h80);
        gie = 1'b1;
        repeat (3) @(negedge clock);
        `CHECK_EQ(irq, 1'b1)
        ee = 1'b1;
        repeat (3) @(negedge clock);
        `CHECK_EQ(irq, 1'b0)
        ee = 1'b0;
        reg_wr(REG_MEM_ADDR, 1'b0, 8'h81);
        @(negedge clock);
        `CHECK_EQ(irq, 1'b0)
        repeat (6) @(negedge clock);
        `CHECK_EQ(irq, 1'b1)
        reg_wr(REG_MEM_ADDR, 1'b0, 8'h83);
        exec(1'b1, 16'h0080, 0);
        `CHECK_EQ(irq, 1'b0)
        wait_idle();
        repeat (3) @(negedge clock);
        `CHECK_EQ(irq, 1'b1)
        gie = 1'b0;
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        t_regs();
        t_illegal();
        t_fill();
        t_prog();
        t_read();
        t_irq();
        wrap_up();
    end
    // the whole run is under two thousand cycles, so this only trips on a hang
    initial begin
        #(25 * 20000);
        error_cnt++;
        wrap_up();
    end
endmodule
